// ===== bench/core_model.sv
`timescale 1ns/1ps
// ==================================================================
// Core arithmetic side: one-cycle event and load pulses, held request
module core_model (
    // Clock
    input  wire logic                 hclk,
    // Towards the block
    output trap_ctl_pkg::trap_events_t trap_events,
    output trap_ctl_pkg::level_load_t  level_load,
    output trap_ctl_pkg::irq_req_t     irq_req
);
    import trap_ctl_pkg::*;
    initial begin
        trap_events = '0;
        level_load  = '0;
        irq_req     = '0;
    end
    task fire(input logic [6:0] e);
        trap_events <= e;
        @(posedge hclk);
        trap_events <= '0;
    endtask : fire
    // Only path that can raise the top level bit
    task load(input logic [3:0] l);
        level_load <= {1'b1, l};
        @(posedge hclk);
        level_load <= '0;
    endtask : load
    task req(input logic p, input logic [2:0] r);
        irq_req <= {p, r};
    endtask : req
endmodule : core_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
    import trap_ctl_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
    logic        nesting_disable, trap_req, irq_take;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
    logic [3:0]  cpu_level;
    logic [15:0] flg [7] = '{16'h4010, 16'h2010, 16'h1010, 16'h0810, 16'h0090, 16'h0050, 16'h0020};
    int          err_count = 0, n_compared = 0, cyc = 0;
    trap_events_t ev;
    level_load_t  ld;
    irq_req_t     rq;
    always #5 hclk = ~hclk;
    core_model core (.hclk(hclk), .trap_events(ev), .level_load(ld), .irq_req(rq));
    cpu_priority_trap_status dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trap_events(ev), .level_load(ld),
        .irq_req(rq), .cpu_level(cpu_level), .nesting_disable(nesting_disable), .trap_req(trap_req),
        .irq_take(irq_take), .irq(irq));
    task close_out;
        if (err_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    // Ready is looked at mid-cycle so the edge that follows is known to complete
    task wait_rdy;
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        d = hrdata;
        @(posedge hclk);
    endtask : wait_rdy
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy;
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
    endtask : xfer
    task rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(0, a, 0);
        `CHK("rdata", e, d)
    endtask : rchk
    task take_chk(input logic e);
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        `CHK("irq_take", e, irq_take)
        @(posedge hclk);
    endtask : take_chk
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            close_out;
        end
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1;
        for (int i = 0; i < 6; i++) rchk(i * 4, 0);
        xfer(1, 8'h14, 32'hFFFF);
        rchk(8'h14, 0);
        xfer(1, CSW_OFS, 32'hE0);
        rchk(CSW_OFS, 32'hE0);
        `CHK("level", 4'h7, cpu_level)
        xfer(1, CCW_OFS, 32'h8);
        rchk(CCW_OFS, 0);
        core.load(4'hA);
        rchk(CCW_OFS, 32'h8);
        rchk(CSW_OFS, 32'h40);
        core.req(1, 3'h7);
        take_chk(0);
        xfer(1, CCW_OFS, 0);
        rchk(CCW_OFS, 0);
        `CHK("level", 4'h2, cpu_level)
        take_chk(1);
        core.req(1, 3'h2);
        take_chk(0);
        core.req(0, 3'h0);
        xfer(1, ICO_OFS, 32'h8000);
        xfer(1, CSW_OFS, 32'h20);
        rchk(CSW_OFS, 32'h40);
        `CHK("nest", 1'b1, nesting_disable)
        xfer(1, ICO_OFS, 0);
        xfer(1, CSW_OFS, 32'h20);
        rchk(CSW_OFS, 32'h20);
        core.fire(7'h78);
        rchk(ICO_OFS, 0);
        rchk(EVT_STAT_OFS, 0);
        for (int k = 0; k < 7; k++) begin
            xfer(1, ICO_OFS, 32'h700);
            xfer(1, EVT_STAT_OFS, 32'h7F);
            core.fire(7'h40 >> k);
            rchk(ICO_OFS, {16'h0, flg[k] | 16'h0700});
            rchk(EVT_STAT_OFS, 32'h1 << k);
        end
        `CHK("irq", 1'b0, irq)
        xfer(1, EVT_MASK_OFS, 32'h40);
        rchk(EVT_MASK_OFS, 32'h40);
        `CHK("irq", 1'b1, irq)
        xfer(1, EVT_STAT_OFS, 32'h40);
        rchk(EVT_STAT_OFS, 0);
        `CHK("irq", 1'b0, irq)
        close_out;
    end
endmodule : tb_top

// ===== bench/trap_status_chk.sv
`timescale 1ns/1ps
// ==================================================================
// Port checker
module trap_chk (
    // Clock and reset
    input wire logic                  hclk,
    input wire logic                  hresetn,
    // Watched ports
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input trap_ctl_pkg::trap_events_t trap_events,
    input trap_ctl_pkg::level_load_t  level_load,
    input trap_ctl_pkg::irq_req_t     irq_req,
    input wire logic [3:0]            cpu_level,
    input wire logic                  nesting_disable,
    input wire logic                  trap_req,
    input wire logic                  irq_take
);
    import trap_ctl_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
    a_wait_once: assert property (!hreadyout |=> hreadyout) else $error("wait longer than one cycle");
    a_load_level: assert property (level_load.load |=> cpu_level == $past(level_load.level))
        else $error("level load lost");
    a_top_locked: assert property (!level_load.load && !cpu_level[3] |=> !cpu_level[3])
        else $error("top bit set by software");
    a_nest_lock: assert property (nesting_disable && !level_load.load |=> $stable(cpu_level[2:0]))
        else $error("level moved while nesting locked");
    a_top_blocks: assert property (irq_take |-> !$past(cpu_level[3])) else $error("take with top bit");
    a_take_prio: assert property (irq_take == $past(irq_req.pending && irq_req.prio > cpu_level))
        else $error("take decision wrong");
    a_math_trap: assert property (trap_events.bad_shift || trap_events.div_zero || trap_events.dma_fault
        |=> trap_req) else $error("trap missing");
    a_trap_cause: assert property (trap_req |-> $past(trap_events != '0)) else $error("trap without event");
    c_take: cover property (irq_take);
    c_trap: cover property (trap_req);
    c_top: cover property (cpu_level[3]);
endmodule : trap_chk

bind cpu_priority_trap_status trap_chk chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .hresp(hresp), .trap_events(trap_events), .level_load(level_load), .irq_req(irq_req),
    .cpu_level(cpu_level), .nesting_disable(nesting_disable), .trap_req(trap_req), .irq_take(irq_take));

// ===== verilog/cpu_priority_trap_status.sv
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Current CPU level lives in bits 7..5 of the core status word; 111 blocks users.
// - Effective four-bit level puts core control bit 3 above the three status bits.
// - With the top level bit set, every user interrupt is blocked.
// - Software writes to the three level bits are ignored while nesting is disabled.
// - Core control bit 3 shows level above 7; resets zero; software may only clear.
// - Control bit 15 disables interrupt nesting when set; resets to zero.
// - Bit 14 flags a trap caused by accumulator A overflow.
// - Bit 13 flags a trap caused by accumulator B overflow.
// - Bits 12 and 11 flag catastrophic overflow traps of accumulators A and B.
// - Overflow traps for A and B need enables at bits 10 and 9; both reset zero.
// - Catastrophic overflow traps need enable bit 8.
// - Bit 7 flags a math trap caused by an invalid accumulator shift.
// - Bit 6 flags a math trap caused by division by zero.
// - Bit 5 flags a DMA controller error trap.
// - Bit 4 flags any math error trap.
// - Software can never set the top level bit.
// - Software changes the CPU level by writing the three status-word bits.
module cpu_priority_trap_status (
    // Clock and reset
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    // AHB-Lite slave
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic                            hresp,
    output logic [31:0]                     hrdata,
    // Core arithmetic and exception logic
    input  trap_ctl_pkg::trap_events_t      trap_events,
    input  trap_ctl_pkg::level_load_t       level_load,
    input  trap_ctl_pkg::irq_req_t          irq_req,
    output logic [3:0]                      cpu_level,
    output logic                            nesting_disable,
    output logic                            trap_req,
    output logic                            irq_take,
    // Interrupt to software
    output logic                            irq
);
    import trap_ctl_pkg::*;

    state_t st_q;
    state_t st_d;

    // ==================================================================
    // Helpers
    function automatic logic [3:0] eff_level(input state_t s);
        eff_level = {s.cpu_level_top_bit, s.cpu_level_low_bits};
    endfunction : eff_level

    function automatic logic [31:0] read_word(input logic [7:0] a, input state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            CSW_OFS:      w[LEVEL_MSB:LEVEL_LSB] = s.cpu_level_low_bits;
            CCW_OFS:      w[TOP_BIT_POS]         = s.cpu_level_top_bit;
            ICO_OFS:      w[15:0]                = s.interrupt_control_one;
            EVT_STAT_OFS: w[NUM_EVENTS-1:0]      = s.evt_stat;
            EVT_MASK_OFS: w[NUM_EVENTS-1:0]      = s.evt_mask;
            default:      w = 32'h0000_0000;
        endcase
        read_word = w;
    endfunction : read_word

    // ==================================================================
    // Next state
    logic                  take_ova;
    logic                  take_ovb;
    logic                  take_cata;
    logic                  take_catb;
    logic                  math_trap;
    logic [NUM_EVENTS-1:0] ev_vec;
    logic                  addr_ok;

    always_comb begin
        st_d = st_q;

        // Overflow traps are gated by their enables; shift and divide always trap
        take_ova  = trap_events.acc_a_ovf & st_q.interrupt_control_one[OVA_EN_POS];
        take_ovb  = trap_events.acc_b_ovf & st_q.interrupt_control_one[OVB_EN_POS];
        take_cata = trap_events.acc_a_cat & st_q.interrupt_control_one[CAT_EN_POS];
        take_catb = trap_events.acc_b_cat & st_q.interrupt_control_one[CAT_EN_POS];
        math_trap = take_ova | take_ovb | take_cata | take_catb
                  | trap_events.bad_shift | trap_events.div_zero;

        ev_vec = '0;
        ev_vec[EV_OVA]   = take_ova;
        ev_vec[EV_OVB]   = take_ovb;
        ev_vec[EV_CATA]  = take_cata;
        ev_vec[EV_CATB]  = take_catb;
        ev_vec[EV_SHIFT] = trap_events.bad_shift;
        ev_vec[EV_DIV0]  = trap_events.div_zero;
        ev_vec[EV_DMA]   = trap_events.dma_fault;

        // Software writes land in the data phase
        if (st_q.phase == BUS_WRITE) begin
            case (st_q.ph_addr)
                CSW_OFS: begin
                    if (!st_q.interrupt_control_one[NEST_POS]) begin
                        st_d.cpu_level_low_bits = hwdata[LEVEL_MSB:LEVEL_LSB];
                    end
                end
                CCW_OFS: begin
                    // Clear only: a one written here is dropped
                    if (!hwdata[TOP_BIT_POS]) begin
                        st_d.cpu_level_top_bit = 1'b0;
                    end
                end
                ICO_OFS:      st_d.interrupt_control_one = hwdata[15:0] & ICO_RW_MASK;
                EVT_STAT_OFS: st_d.evt_stat = st_q.evt_stat & ~hwdata[NUM_EVENTS-1:0];
                EVT_MASK_OFS: st_d.evt_mask = hwdata[NUM_EVENTS-1:0];
                default:      st_d.evt_mask = st_q.evt_mask;
            endcase
        end

        // Hardware sets after the software write so a same-cycle set wins
        if (take_ova)              st_d.interrupt_control_one[OVA_FLAG_POS] = 1'b1;
        if (take_ovb)              st_d.interrupt_control_one[OVB_FLAG_POS] = 1'b1;
        if (take_cata)             st_d.interrupt_control_one[CATA_POS]     = 1'b1;
        if (take_catb)             st_d.interrupt_control_one[CATB_POS]     = 1'b1;
        if (trap_events.bad_shift) st_d.interrupt_control_one[SHIFT_POS]    = 1'b1;
        if (trap_events.div_zero)  st_d.interrupt_control_one[DIV0_POS]     = 1'b1;
        if (trap_events.dma_fault) st_d.interrupt_control_one[DMA_POS]      = 1'b1;
        if (math_trap)             st_d.interrupt_control_one[MATH_POS]     = 1'b1;
        st_d.evt_stat = st_d.evt_stat | ev_vec;

        // Core level load (trap or interrupt entry/return) overrides software;
        // it is the only path that can raise the top bit
        if (level_load.load) begin
            st_d.cpu_level_low_bits = level_load.level[2:0];
            st_d.cpu_level_top_bit  = level_load.level[3];
        end

        st_d.trap_req = math_trap | trap_events.dma_fault;

        // Strict comparison; top bit alone already blocks, checked explicitly too
        st_d.irq_take = irq_req.pending
                      & ~st_q.cpu_level_top_bit
                      & ({1'b0, irq_req.prio} > eff_level(st_q));

        // Bus phase tracking; reads take one wait state so read data comes
        // from a flip-flop and sees any write that just completed
        addr_ok = hsel & htrans[1] & hready;
        case (st_q.phase)
            BUS_READ_WAIT: begin
                st_d.rdata = read_word(st_q.ph_addr, st_q);
                st_d.phase = BUS_READ_DONE;
            end
            default: begin
                if (addr_ok) begin
                    st_d.phase   = hwrite ? BUS_WRITE : BUS_READ_WAIT;
                    st_d.ph_addr = haddr[7:0];
                end else begin
                    st_d.phase = BUS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q.cpu_level_low_bits    <= LEVEL_RESET;
            st_q.cpu_level_top_bit     <= 1'b0;
            st_q.interrupt_control_one <= ICO_RESET;
            st_q.evt_stat              <= '0;
            st_q.evt_mask              <= '0;
            st_q.phase                 <= BUS_IDLE;
            st_q.ph_addr               <= 8'h00;
            st_q.rdata                 <= 32'h0000_0000;
            st_q.irq_take              <= 1'b0;
            st_q.trap_req              <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ==================================================================
    // Outputs
    assign hreadyout       = (st_q.phase != BUS_READ_WAIT);
    assign hresp           = 1'b0;
    assign hrdata          = st_q.rdata;
    assign cpu_level       = eff_level(st_q);
    assign nesting_disable = st_q.interrupt_control_one[NEST_POS];
    assign trap_req        = st_q.trap_req;
    assign irq_take        = st_q.irq_take;
    assign irq             = |(st_q.evt_stat & st_q.evt_mask);

endmodule : cpu_priority_trap_status

// ===== verilog/trap_ctl_pkg.sv
package trap_ctl_pkg;

    // ==================================================================
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] CSW_OFS      = 8'h00;
    localparam logic [7:0] CCW_OFS      = 8'h04;
    localparam logic [7:0] ICO_OFS      = 8'h08;
    localparam logic [7:0] EVT_STAT_OFS = 8'h0C;
    localparam logic [7:0] EVT_MASK_OFS = 8'h10;

    // ==================================================================
    // Field positions
    localparam int LEVEL_LSB    = 5;
    localparam int LEVEL_MSB    = 7;
    localparam int TOP_BIT_POS  = 3;
    localparam int NEST_POS     = 15;
    localparam int OVA_FLAG_POS = 14;
    localparam int OVB_FLAG_POS = 13;
    localparam int CATA_POS     = 12;
    localparam int CATB_POS     = 11;
    localparam int OVA_EN_POS   = 10;
    localparam int OVB_EN_POS   = 9;
    localparam int CAT_EN_POS   = 8;
    localparam int SHIFT_POS    = 7;
    localparam int DIV0_POS     = 6;
    localparam int DMA_POS      = 5;
    localparam int MATH_POS     = 4;

    // ==================================================================
    // Reset values and masks
    localparam logic [15:0] ICO_RESET   = 16'h0000;
    localparam logic [15:0] ICO_RW_MASK = 16'hFFF0;
    localparam logic [2:0]  LEVEL_RESET = 3'h0;

    // ==================================================================
    // Event status bits
    localparam int NUM_EVENTS = 7;
    localparam int EV_OVA     = 0;
    localparam int EV_OVB     = 1;
    localparam int EV_CATA    = 2;
    localparam int EV_CATB    = 3;
    localparam int EV_SHIFT   = 4;
    localparam int EV_DIV0    = 5;
    localparam int EV_DMA     = 6;

    // ==================================================================
    // Carriers
    typedef struct packed {
        logic acc_a_ovf;
        logic acc_b_ovf;
        logic acc_a_cat;
        logic acc_b_cat;
        logic bad_shift;
        logic div_zero;
        logic dma_fault;
    } trap_events_t;

    typedef struct packed {
        logic       load;
        logic [3:0] level;
    } level_load_t;

    typedef struct packed {
        logic       pending;
        logic [2:0] prio;
    } irq_req_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ_WAIT,
        BUS_READ_DONE
    } bus_phase_t;

    typedef struct packed {
        logic [2:0]            cpu_level_low_bits;
        logic                  cpu_level_top_bit;
        logic [15:0]           interrupt_control_one;
        logic [NUM_EVENTS-1:0] evt_stat;
        logic [NUM_EVENTS-1:0] evt_mask;
        bus_phase_t            phase;
        logic [7:0]            ph_addr;
        logic [31:0]           rdata;
        logic                  irq_take;
        logic                  trap_req;
    } state_t;

endpackage : trap_ctl_pkg
